// *** sbs_buf.sv ***
`timescale 1ns/10ps
package sbs_pkg;
   localparam int unsigned SBS_ADDR_W = 18;
   localparam int unsigned SBS_DATA_W = 36;
   localparam int unsigned SBS_LANES = 4;
   localparam int unsigned SBS_BURST_CNT_W = 2;
   localparam logic [1:0] SBS_CNT_RST = 2'h0;
   localparam logic [1:0] SBS_CNT_ONE = 2'h1;
   localparam logic [1:0] SBS_BUF_FULL = 2'h2;
   localparam logic [1:0] SBS_BUF_RST = 2'h0;
   typedef enum logic [1:0] {
      SBS_IDLE = 2'b00,
      SBS_READ = 2'b01,
      SBS_WRITE = 2'b10
   } sbs_burst_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module sbs_buf import sbs_pkg::*; #(
   parameter int unsigned W = 36
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [W-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   output logic [W-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   typedef struct packed {
      logic [W-1:0] head;
      logic [W-1:0] tail;
      logic [1:0] cnt;
      logic vld;
   } sbs_buf_state_t;

   sbs_buf_state_t st_r;
   sbs_buf_state_t st_nxt;
   logic push;
   logic pop;

   // A full buffer still takes a word while the receiver drains one, so only a real stall refuses.
   assign in_ready_out = (st_r.cnt != SBS_BUF_FULL) | out_ready_in;
   assign out_valid_out = st_r.vld;
   assign out_data_out = st_r.head;
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_comb begin
      st_nxt = st_r;
      // The head always holds the oldest word; the tail only fills when the head will still hold an older word after the cycle.
      if (pop) begin
         st_nxt.head = st_r.tail;
      end
      if (push) begin
         if ((st_r.cnt == SBS_BUF_RST) || ((st_r.cnt == SBS_CNT_ONE) && pop)) begin
            st_nxt.head = in_data_in;
         end else begin
            st_nxt.tail = in_data_in;
         end
      end
      st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
      st_nxt.vld = (st_nxt.cnt != SBS_BUF_RST);
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

// *** sbs_sram.sv ***
`timescale 1ns/10ps

// Notes on behaviour
// - A burst steps only the two low address bits through four words.
// - Load/advance sampled low ends any burst and loads address and controls.
// - While advancing a burst, the read/write select input is ignored.
// - Burst direction is fixed by read/write captured at the load edge.
// - A write starts when read/write is low on a selected load edge.
// - Write data arrives two cycles after its byte selects and pairs with them.
// - A clock edge with the clock gate high is treated as never happening.
// - On a suppressed edge every core register, pipeline and counter holds its value; the read buffer can still pop.
module sbs_sram import sbs_pkg::*; #(
   parameter int unsigned AW = SBS_ADDR_W,
   parameter int unsigned DW = SBS_DATA_W,
   parameter int unsigned LANES = SBS_LANES
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic chip_select_low_a_n_in,
   input wire logic chip_select_pair_in,
   input wire logic chip_select_low_b_n_in,
   input wire logic advance_or_load_select_in,
   input wire logic rd_wr_n_in,
   input wire logic [LANES-1:0] byte_lane_write_select_n_in,
   input wire logic clock_gate_n_in,
   input wire logic burst_order_select_in,
   input wire logic [DW-1:0] dq_in,
   output logic [DW-1:0] dq_out,
   output logic dq_oe_out,
   output logic [DW-1:0] rd_word_out,
   output logic rd_word_valid_out,
   input wire logic rd_word_ready_in
);
   localparam int unsigned LANE_W = DW / LANES;

   typedef struct packed {
      sbs_burst_t burst;
      logic [AW-1:0] base;
      logic [SBS_BURST_CNT_W-1:0] cnt;
      logic s1_v;
      logic s1_w;
      logic [AW-1:0] s1_a;
      logic [LANES-1:0] s1_be_n;
      logic s2_v;
      logic s2_w;
      logic [AW-1:0] s2_a;
      logic [LANES-1:0] s2_be_n;
      logic [DW-1:0] dout;
      logic oe;
   } sbs_state_t;

   sbs_state_t st_r;
   sbs_state_t st_nxt;
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic buf_ready;
   logic en;
   logic selected;
   logic [SBS_BURST_CNT_W-1:0] step;
   logic [SBS_BURST_CNT_W-1:0] low_bits;
   logic rd_push;

   ////////////////////////////////////////////////////////////////////////////

   // gated edges ignored
   // A full read buffer with a stalled receiver also freezes the core, so no word is lost.
   assign en = ~clock_gate_n_in & buf_ready;
   assign selected = ~chip_select_low_a_n_in & chip_select_pair_in & ~chip_select_low_b_n_in;
   assign rd_push = en & st_r.s2_v & ~st_r.s2_w;
   assign step = st_r.cnt + SBS_CNT_ONE;

   always_comb begin
      if (burst_order_select_in) begin
         low_bits = st_r.base[SBS_BURST_CNT_W-1:0] ^ step;
      end else begin
         low_bits = st_r.base[SBS_BURST_CNT_W-1:0] + step;
      end
   end

   always_comb begin
      st_nxt = st_r;
      if (en) begin
         st_nxt.s1_v = 1'b0;
         st_nxt.s1_be_n = byte_lane_write_select_n_in;
         if (!advance_or_load_select_in) begin
            st_nxt.cnt = SBS_CNT_RST;
            st_nxt.base = addr_in;
            st_nxt.s1_a = addr_in;
            if (selected) begin
               st_nxt.burst = rd_wr_n_in ? SBS_READ : SBS_WRITE;
               st_nxt.s1_v = 1'b1;
               st_nxt.s1_w = ~rd_wr_n_in;
            end else begin
               st_nxt.burst = SBS_IDLE;
            end
         end else begin
            case (st_r.burst)
               SBS_READ, SBS_WRITE: begin
                  st_nxt.cnt = step;
                  st_nxt.s1_a = {st_r.base[AW-1:SBS_BURST_CNT_W], low_bits};
                  st_nxt.s1_v = 1'b1;
                  st_nxt.s1_w = (st_r.burst == SBS_WRITE);
               end
               default: begin
                  st_nxt.s1_v = 1'b0;
               end
            endcase
         end
         st_nxt.s2_v = st_r.s1_v;
         st_nxt.s2_w = st_r.s1_w;
         st_nxt.s2_a = st_r.s1_a;
         st_nxt.s2_be_n = st_r.s1_be_n;
         st_nxt.oe = st_r.s2_v & ~st_r.s2_w;
         if (st_r.s2_v && !st_r.s2_w) begin
            st_nxt.dout = mem[st_r.s2_a];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_in) begin
      if (en && st_r.s2_v && st_r.s2_w) begin
         for (int i = 0; i < LANES; i++) begin
            if (!st_r.s2_be_n[i]) begin
               mem[st_r.s2_a][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   assign dq_out = st_r.dout;
   assign dq_oe_out = st_r.oe;

   sbs_buf #(
      .W(DW)
   ) u_rd_buf (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .in_data_in(mem[st_r.s2_a]),
      .in_valid_in(rd_push),
      .in_ready_out(buf_ready),
      .out_data_out(rd_word_out),
      .out_valid_out(rd_word_valid_out),
      .out_ready_in(rd_word_ready_in)
   );
endmodule

// *** sbs_host.sv ***
`timescale 1ns/10ps
module sbs_host (
   input wire logic clk_in,
   input wire logic cs_a_n_in,
   input wire logic cs_b_n_in,
   output logic cs_pair_out,
   output logic ready_out
);
   int seed = 32'hb06784b8;
   assign cs_pair_out = !(cs_a_n_in || cs_b_n_in);
   // Stalling one cycle in four lets the read buffer fill and refuse.
   initial ready_out = 1'b1;
   always @(posedge clk_in) ready_out <= $random(seed) % 4 != 0;
endmodule

// *** sbs_sram_monitor.sv ***
`timescale 1ns/10ps
module sbs_sram_mon (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic chip_select_low_a_n_in,
   input wire logic chip_select_low_b_n_in,
   input wire logic chip_select_pair_in,
   input wire logic advance_or_load_select_in,
   input wire logic rd_wr_n_in,
   input wire logic clock_gate_n_in,
   input wire logic rd_word_ready_in,
   input wire logic dq_oe_out,
   input wire logic rd_word_valid_out
);
   // Ready high is taken as enabled, since the buffer stalls only while the consumer waits.
   wire en = !clock_gate_n_in && rd_word_ready_in;
   wire sel = !chip_select_low_a_n_in && !chip_select_low_b_n_in && chip_select_pair_in;
   wire adv = advance_or_load_select_in;
   default clocking dclk @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_ld(bit rd); en && sel && !adv && rd_wr_n_in == rd; endsequence
   sequence s_two; en ##1 en; endsequence
   a_read_lat: assert property (s_ld(1) ##1 s_two |=> dq_oe_out) else $error("no read");
   a_read_push: assert property (s_ld(1) ##1 s_two |=> rd_word_valid_out) else $error("no push");
   a_write_quiet: assert property (s_ld(0) ##1 s_two |=> !dq_oe_out) else $error("write read");
   a_desel_quiet: assert property (en && !sel && !adv ##1 s_two |=> !dq_oe_out)
      else $error("deselect read");
   a_burst_read: assert property (s_ld(1) ##1 (en && adv) ##1 s_two |=> dq_oe_out)
      else $error("burst read lost");
   a_burst_write: assert property (s_ld(0) ##1 (en && adv) ##1 s_two |=> !dq_oe_out)
      else $error("burst turned");
   a_gate_hold: assert property (clock_gate_n_in |=> $stable(dq_oe_out)) else $error("moved");
   a_rise_enabled: assert property ($rose(dq_oe_out) |-> $past(clock_gate_n_in) == 1'b0)
      else $error("rose when gated");
endmodule
bind sbs_sram sbs_sram_mon mon (.*);

// *** tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   logic clk_in = 0, rst_b_in = 0, ca = 1, cb = 0, cp, adv = 0, rw = 1, cg = 0, bo = 0;
   logic rdy, oe, vo, eo = 0;
   logic [17:0] a = 0;
   logic [3:0] bw = 0, b1, b2;
   logic [35:0] di = 0, dq, wd, eq, w, m [8], q [$];
   logic [2:0] bs, a1, a2;
   int seed = 32'hb06784b8, mismatches = 0, check_count = 0, cyc = 0;
   int r, k1 = 0, k2 = 0, lv = 0, wr, cn, en;
   always #2.5 clk_in = ~clk_in;
   sbs_host host (.clk_in(clk_in), .cs_a_n_in(ca), .cs_b_n_in(cb), .cs_pair_out(cp),
      .ready_out(rdy));
   sbs_sram dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(a),
      .chip_select_low_a_n_in(ca), .chip_select_pair_in(cp), .chip_select_low_b_n_in(cb),
      .advance_or_load_select_in(adv), .rd_wr_n_in(rw), .byte_lane_write_select_n_in(bw),
      .clock_gate_n_in(cg), .burst_order_select_in(bo), .dq_in(di), .dq_out(dq),
      .dq_oe_out(oe), .rd_word_out(wd), .rd_word_valid_out(vo), .rd_word_ready_in(rdy));
   task summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_in) if (rst_b_in) begin
      en = !cg && !(q.size() == 2 && !rdy);
      if (vo && rdy) begin
         w = q.pop_front();
         `CHK("word", w, wd)
      end
      if (en) begin
         eo = k2 == 1;
         if (eo) eq = m[a2];
         if (eo) q.push_back(eq);
         // lanes meet selects from two edges back
         for (int i = 0; i < 4; i++) if (k2 == 2 && !b2[i]) m[a2][i*9+:9] = di[i*9+:9];
         k2 = k1;
         a2 = a1;
         b2 = b1;
         b1 = bw;
         cn = adv ? cn + 1 : 0;
         if (!adv) begin lv = !ca && !cb && cp; bs = a[2:0]; wr = !rw; end
         k1 = lv ? 1 + wr : 0;
         a1 = {bs[2], bo ? bs[1:0] ^ 2'(cn) : bs[1:0] + 2'(cn)};
      end
   end
   always @(negedge clk_in) if (rst_b_in) begin
      `CHK("oe", eo, oe)
      if (eo) `CHK("dq", eq, dq)
   end
   always @(posedge clk_in) if (++cyc == 5000) begin mismatches++; summarize(); end
   initial begin
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk_in);
         r = $random(seed);
         di <= 36'({r, $random(seed)});
         bw <= i < 8 ? 4'h0 : r[3:0];
         adv <= i >= 8 && i != 1500 && r[5:4] != 2'h0;
         rw <= i >= 8 && r[6];
         ca <= i >= 8 && r[9:7] == 3'h0;
         cb <= i >= 8 && r[12:10] == 3'h0;
         cg <= i >= 8 && r[14:13] == 2'h0;
         a <= i < 8 ? 18'(i) : 18'(r[17:15]);
         bo <= i >= 1500;
      end
      summarize();
   end
endmodule
